// >>> hw/pir_router.sv
// Purpose: Routes 64 peripheral requests to seven core general-purpose inputs
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes: Reserved and unused sources default to field 0xF and route nowhere
// Operation
// - Each request goes to at most one core input per its assignment field.
// - Software rewrites assignment fields; new routing applies at once.
// - Assignment value n selects core input n (core_gp_input bit n) for n in 0..6.
// - Sources 0-10 reset to value 0; source 11 reserved, drives nothing.
// - Sources 12-13 reset to value 1, sources 14-19 to value 2.
// - 20-25 value 3, 26-30 value 4, 32-41 value 5, 42 value 6.
// - Mask, status and wake each held in a pair of 32-bit registers.
// - Mask bit set forwards the source to its core input; clear blocks that routing but not wakeup.
// - Status bit reads one while the source asserts its request.
// - Wake-enabled source asserting while core idle raises a wakeup.
`timescale 1ns/10ps
module pir_router (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [63:0] periph_irq,
   input wire logic core_idle,
   output logic [6:0] core_gp_input,
   output logic core_wakeup,
   output logic irq
);
   logic [63:0] src_sync;
   logic [63:0] mask_reg, mask_next;
   logic [63:0] wake_reg, wake_next;
   logic [31:0] assign_reg [pir_pkg::NUM_ASSIGN];
   logic [31:0] assign_next [pir_pkg::NUM_ASSIGN];
   logic [1:0] ev_stat_reg, ev_stat_next;
   logic [1:0] ev_en_reg, ev_en_next;
   pir_pkg::pir_req_s req_reg, req_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [6:0] gp_reg, gp_next;
   logic wake_out_reg, wake_out_next;
   logic [1:0] ev_set;
   logic [1:0] ev_clr;
   logic [7:0] wr_addr;
   logic assign_hit;
   // Per-source field and qualifiers, shared by routing and events
   logic [3:0] src_fld [pir_pkg::NUM_SRC];
   logic [63:0] src_live;
   logic [63:0] src_bad;
   logic [63:0] src_wake;

   // Peripheral requests arrive from other logic; synchronise first
   pir_sync #(.W(pir_pkg::NUM_SRC)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(periph_irq),
      .q(src_sync)
   );

   // Bus address phase capture; write data follows one cycle later
   always_comb begin
      req_next.sel = hsel && hready && (htrans == pir_pkg::HTRANS_NONSEQ);
      req_next.write = hwrite;
      req_next.addr = haddr[7:0];
   end

   // Register write path
   always_comb begin
      mask_next = mask_reg;
      wake_next = wake_reg;
      ev_en_next = ev_en_reg;
      ev_clr = 2'h0;
      assign_next = assign_reg;
      wr_addr = req_reg.addr;
      // Range test keeps the eight assignment words out of the case list
      assign_hit = (wr_addr >= pir_pkg::OFS_ASSIGN0) && (wr_addr <= pir_pkg::OFS_ASSIGN7);
      if (req_reg.sel && req_reg.write) begin
         unique case (wr_addr)
            pir_pkg::OFS_MASK0: mask_next[31:0] = hwdata;
            pir_pkg::OFS_MASK1: mask_next[63:32] = hwdata;
            pir_pkg::OFS_WAKE0: wake_next[31:0] = hwdata;
            pir_pkg::OFS_WAKE1: wake_next[63:32] = hwdata;
            pir_pkg::OFS_IRQ_EN: ev_en_next = hwdata[1:0];
            pir_pkg::OFS_IRQ_CLR: ev_clr = hwdata[1:0];
            default: begin
               if (assign_hit) begin
                  assign_next[wr_addr[4:2]] = hwdata;
               end
            end
         endcase
      end
   end

   // Per-source decode of assignment field, mask and wake enable
   always_comb begin
      for (int s = 0; s < pir_pkg::NUM_SRC; s++) begin
         src_fld[s] = assign_reg[s / pir_pkg::SRC_PER_ASSIGN]
            [(s % pir_pkg::SRC_PER_ASSIGN) * pir_pkg::FIELD_W +: pir_pkg::FIELD_W];
         src_live[s] = src_sync[s] && mask_reg[s];
         src_bad[s] = src_live[s] && (src_fld[s] > pir_pkg::GP_VAL_MAX);
         src_wake[s] = src_sync[s] && wake_reg[s];
      end
   end

   // Routing and wakeup; fields above six route nowhere
   always_comb begin
      gp_next = 7'h00;
      for (int s = 0; s < pir_pkg::NUM_SRC; s++) begin
         if (src_live[s] && !src_bad[s]) begin
            gp_next[src_fld[s][2:0]] = 1'h1;
         end
      end
      // Core idle is a same-clock level, so no sync stages here
      wake_out_next = (|src_wake) && core_idle;
   end

   // Events; set wins over a same-cycle clear
   always_comb begin
      ev_set = 2'h0;
      ev_set[pir_pkg::EV_WAKE] = wake_out_next;
      ev_set[pir_pkg::EV_ASSIGN_BAD] = |src_bad;
      ev_stat_next = (ev_stat_reg & ~ev_clr) | ev_set;
   end

   // Read data from next values for mask, wake, enable and assignment words, so a read right behind a write sees it
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (req_next.sel && !req_next.write) begin
         unique case (req_next.addr)
            pir_pkg::OFS_MASK0: rdata_next = mask_next[31:0];
            pir_pkg::OFS_MASK1: rdata_next = mask_next[63:32];
            pir_pkg::OFS_STAT0: rdata_next = src_sync[31:0];
            pir_pkg::OFS_STAT1: rdata_next = src_sync[63:32];
            pir_pkg::OFS_WAKE0: rdata_next = wake_next[31:0];
            pir_pkg::OFS_WAKE1: rdata_next = wake_next[63:32];
            pir_pkg::OFS_IRQ_STAT: rdata_next = {30'h0, ev_stat_reg};
            pir_pkg::OFS_IRQ_EN: rdata_next = {30'h0, ev_en_next};
            default: begin
               if (req_next.addr >= pir_pkg::OFS_ASSIGN0 &&
                   req_next.addr <= pir_pkg::OFS_ASSIGN7) begin
                  rdata_next = assign_next[req_next.addr[4:2]];
               end
            end
         endcase
      end
   end

   // Bus pipeline
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_reg <= '0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         req_reg <= req_next;
         rdata_reg <= rdata_next;
      end
   end

   // Software configuration; mask resets closed so nothing fires early
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_reg <= {pir_pkg::MASK_RESET, pir_pkg::MASK_RESET};
         wake_reg <= {pir_pkg::WAKE_RESET, pir_pkg::WAKE_RESET};
         ev_en_reg <= 2'h0;
      end else begin
         mask_reg <= mask_next;
         wake_reg <= wake_next;
         ev_en_reg <= ev_en_next;
      end
   end

   // Assignment words
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         assign_reg <= pir_pkg::ASSIGN_RESET;
      end else begin
         assign_reg <= assign_next;
      end
   end

   // Core side outputs, registered so the core sees clean levels
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gp_reg <= 7'h00;
         wake_out_reg <= 1'h0;
      end else begin
         gp_reg <= gp_next;
         wake_out_reg <= wake_out_next;
      end
   end

   // Sticky event status
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_stat_reg <= 2'h0;
      end else begin
         ev_stat_reg <= ev_stat_next;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'h1;
   assign hresp = 1'h0;
   assign hrdata = rdata_reg;
   assign core_gp_input = gp_reg;
   assign core_wakeup = wake_out_reg;
   assign irq = |(ev_stat_reg & ev_en_reg);
endmodule // pir_router

// >>> hw/pir_pkg.sv
// Purpose: Constants and types for the peripheral interrupt router
// Assumes: AHB-Lite register access, 32-bit words
// Notes: Byte offsets are word aligned
package pir_pkg;
   localparam int NUM_SRC = 64;
   localparam int NUM_GP = 7;
   localparam int NUM_ASSIGN = 8;
   localparam int FIELD_W = 4;
   localparam int SRC_PER_ASSIGN = 8;
   localparam logic [3:0] GP_VAL_MAX = 4'h6;
   // Register byte offsets
   localparam logic [7:0] OFS_MASK0 = 8'h00;
   localparam logic [7:0] OFS_MASK1 = 8'h04;
   localparam logic [7:0] OFS_STAT0 = 8'h08;
   localparam logic [7:0] OFS_STAT1 = 8'h0C;
   localparam logic [7:0] OFS_WAKE0 = 8'h10;
   localparam logic [7:0] OFS_WAKE1 = 8'h14;
   localparam logic [7:0] OFS_ASSIGN0 = 8'h20;
   localparam logic [7:0] OFS_ASSIGN7 = 8'h3C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
   localparam logic [7:0] OFS_IRQ_EN = 8'h44;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h48;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] WAKE_RESET = 32'h0000_0000;
   // Default assignment words, source 8k in bits [3:0]; reserved fields hold 0xF
   localparam logic [31:0] ASSIGN_RESET [NUM_ASSIGN] = '{
      32'h0000_0000, 32'h2211_F000, 32'h3333_2222, 32'hF444_4433,
      32'h5555_5555, 32'hFFFF_F655, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
   // Interrupt event bits
   localparam int EV_WAKE = 0;
   localparam int EV_ASSIGN_BAD = 1;
   localparam int EV_W = 2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic sel;
      logic write;
      logic [7:0] addr;
   } pir_req_s;
endpackage

// >>> hw/pir_sync.sv
// Purpose: Two-flop synchroniser for a vector of levels
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second
`timescale 1ns/10ps
module pir_sync #(
   parameter int W = 64
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule // pir_sync

// >>> dv/pir_router_chk.sv
// Purpose: Port checks for pir_router
// Assumes: Zero wait slave, two sync stages
// Notes: Routing latency three edges
`timescale 1ns/10ps
module pir_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [63:0] periph_irq,
   input wire logic core_idle,
   input wire logic [6:0] core_gp_input,
   input wire logic core_wakeup
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_one_input: assert property ($onehot0($past(periph_irq, 3)) |-> $onehot0(core_gp_input))
      else $error("more than one core input");
   a_gp_cause: assert property (core_gp_input != 7'h0 |-> $past(periph_irq, 3) != 64'h0)
      else $error("core input without source");
   a_gp_quiet: assert property ((periph_irq == 64'h0)[*4] |=> core_gp_input == 7'h0 && !core_wakeup)
      else $error("output with no source");
   a_gp_steady: assert property ((htrans == 2'h0 && $stable(periph_irq))[*5] |=> $stable(core_gp_input))
      else $error("routing moved by itself");
   a_wake_idle: assert property (core_wakeup |-> $past(core_idle))
      else $error("wakeup while core busy");
   a_wake_src: assert property (core_wakeup |-> $past(periph_irq, 3) != 64'h0)
      else $error("wakeup without source");
   a_unmapped_zero: assert property (hsel && hready && htrans == pir_pkg::HTRANS_NONSEQ && !hwrite
      && haddr[7:0] == 8'h80 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // pir_chk
bind pir_router pir_chk i_chk (.*);

// >>> dv/pir_core_model.sv
// Purpose: Core side model, sleeps on request
// Assumes: Idle is a level
// Notes: Wakeup wins over sleep
`timescale 1ns/10ps
module pir_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sleep_req,
   input wire logic core_wakeup,
   output logic core_idle
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) core_idle <= 1'b0;
      else core_idle <= !core_wakeup && (sleep_req || core_idle);
   end
endmodule // pir_core_model

// >>> dv/pir_router_tb.sv
// Purpose: Self-checking bench for pir_router
// Assumes: Single word transfers
// Notes: Rows hold address and reset word
`timescale 1ns/10ps
module pir_router_tb;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_req = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0] htrans = 0;
   logic [63:0] periph_irq = 0;
   logic [6:0] core_gp_input;
   logic hreadyout, hresp, core_idle, core_wakeup, irq;
   int err_count = 0, checks = 0, cyc = 0;
   logic [39:0] rows [12] = '{40'h00_00000000, 40'h04_00000000, 40'h10_00000000,
      40'h14_00000000, 40'h20_00000000, 40'h24_2211F000, 40'h28_33332222,
      40'h2C_F4444433, 40'h30_55555555, 40'h34_FFFFF655, 40'h40_00000000, 40'h80_00000000};
   int src [8] = '{0, 10, 12, 14, 20, 26, 32, 42};
   int tgt [8] = '{0, 0, 1, 2, 3, 4, 5, 6};
   pir_router i_dut (.*, .hsize(3'h2), .hready(hreadyout));
   pir_core_model i_core (.*);
   initial forever #10 hclk = ~hclk;
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= pir_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, s, e);
      end
   endtask
   task results;
      if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Hang guard, run needs well under a thousand cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         results();
      end
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (rows[i]) begin
         bus(1'b0, rows[i][39:32], 32'h0);
         chk(q, rows[i][31:0]);
      end
      bus(1'b1, 8'h00, 32'hFFFFFFFF);
      bus(1'b1, 8'h04, 32'hFFFFFFFF);
      bus(1'b0, 8'h04, 32'h0);
      chk(q, 32'hFFFFFFFF);
      foreach (src[i]) begin
         periph_irq <= 64'h1 << src[i];
         repeat (4) @(posedge hclk);
         chk({25'h0, core_gp_input}, 32'h1 << tgt[i]);
         bus(1'b0, src[i] < 32 ? 8'h08 : 8'h0C, 32'h0);
         chk(q, 32'h1 << (src[i] % 32));
      end
      periph_irq <= 64'h800;
      repeat (4) @(posedge hclk);
      chk({25'h0, core_gp_input}, 32'h0);
      bus(1'b1, 8'h20, 32'h6);
      periph_irq <= 64'h1;
      repeat (4) @(posedge hclk);
      chk({25'h0, core_gp_input}, 32'h40);
      bus(1'b1, 8'h00, 32'h0);
      repeat (2) @(posedge hclk);
      chk({25'h0, core_gp_input}, 32'h0);
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b1, 8'h44, 32'h1);
      chk({31'h0, core_wakeup}, 32'h0);
      sleep_req <= 1'b1;
      @(posedge hclk);
      sleep_req <= 1'b0;
      repeat (3) @(posedge hclk);
      chk({31'h0, core_idle}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h3);
      bus(1'b1, 8'h44, 32'h0);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 8'h48, 32'h3);
      bus(1'b1, 8'h44, 32'h1);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      results();
   end
endmodule // pir_router_tb
